//--- logic/phymi_media_if.sv
// mac-side media interface: rx pin drive, tx decode, col and crs
// Functional notes
// - low receive nibble driven in every mode
// - upper receive bits used only in gmii
// - rgmii tx control: enable and error, ddr
// - rx valid high while data on bus
// - rgmii rx control: valid and error, ddr
// - rx error high on detected receive error
// - rgmii leaves separate rx error unused
// - half duplex collision on tx and rx
// - full duplex holds collision low
// - rgmii leaves collision and carrier unused
// - half duplex carrier on rx or tx
// - full duplex carrier only on receive, below 1000M; held low at 1000M
// - mii tx clock from device, continuous
// - rx clock rate follows line speed
// - tx error marks invalid code-groups
`timescale 1ns/10ps
`default_nettype none
module phymi_media_if #(
   parameter int FIFO_DEPTH = phymi_pkg::RX_FIFO_DEPTH
) (
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   input  wire phymi_pkg::phymi_mode_t    mode_in,
   input  wire phymi_pkg::phymi_speed_t   speed_in,
   input  wire logic                      full_duplex_in,
   input  wire logic                      line_carrier_in,
   input  wire phymi_pkg::phymi_rx_word_t rx_word_in,
   input  wire logic                      rx_valid_in,
   output logic                           rx_ready_out,
   input  wire logic                      gtx_clk_in,
   input  wire logic [7:0]                txd_in,
   input  wire logic                      tx_en_ctrl_in,
   input  wire logic                      tx_er_in,
   output logic                           rx_clk_out,
   output logic [7:0]                     rxd_out,
   output logic                           rx_dv_ctrl_out,
   output logic                           rx_er_out,
   output logic                           col_out,
   output logic                           crs_out,
   output logic                           tx_clk_out,
   output phymi_pkg::phymi_tx_byte_t      tx_byte_out,
   output logic                           tx_byte_valid_out,
   output logic                           tx_active_out
);

   typedef struct packed {
      phymi_pkg::phymi_mode_t    mode;
      phymi_pkg::phymi_speed_t   speed;
      logic                      fd;
      phymi_pkg::phymi_pins_t    s1;
      phymi_pkg::phymi_pins_t    s2;
      phymi_pkg::phymi_pins_t    s3;
      logic [phymi_pkg::QCNT_W-1:0] qcnt;
      logic [1:0]                ph;
      logic                      rxclk;
      logic                      txclk;
      logic [7:0]                rxd;
      logic                      dvc;
      logic                      rxer;
      logic                      hi_pend;
      phymi_pkg::phymi_rx_word_t cur;
      logic                      col;
      logic                      crs;
      logic [3:0]                tx_nib;
      logic                      tx_nib_er;
      logic                      tx_half;
      logic                      tx_en_r;
      phymi_pkg::phymi_tx_byte_t txb;
      logic                      txv;
      logic                      txact;
   } phymi_st_t;

   phymi_st_t                 q;
   phymi_st_t                 d;
   phymi_pkg::phymi_pins_t    pins;
   phymi_pkg::phymi_rx_word_t fifo_word;
   logic                      fifo_valid;
   logic                      pop;
   logic                      tick;
   logic                      gtx_rise;
   logic                      gtx_fall;
   logic                      is_rgmii;

   function automatic logic [phymi_pkg::QCNT_W-1:0] quarter(
      input phymi_pkg::phymi_speed_t s
   );
      case (s)
         phymi_pkg::PHYMI_10M:
            quarter = phymi_pkg::QCNT_W'(phymi_pkg::QTR10_CYC);
         phymi_pkg::PHYMI_100M:
            quarter = phymi_pkg::QCNT_W'(phymi_pkg::QTR100_CYC);
         default:
            quarter = phymi_pkg::QCNT_W'(phymi_pkg::QTR1000_CYC);
      endcase
   endfunction

   phymi_fifo #(
      .WIDTH (phymi_pkg::RX_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (rx_valid_in),
      .in_data_in    (rx_word_in),
      .in_ready_out  (rx_ready_out),
      .out_valid_out (fifo_valid),
      .out_data_out  (fifo_word),
      .out_ready_in  (pop)
   );

   assign pins     = '{gtx: gtx_clk_in, en: tx_en_ctrl_in, er: tx_er_in,
                       d: txd_in};
   assign tick     = (q.qcnt == '0);
   // mac clock edges seen between the second and third sync stage
   assign gtx_rise = q.s2.gtx && !q.s3.gtx;
   assign gtx_fall = !q.s2.gtx && q.s3.gtx;
   assign is_rgmii = (q.mode == phymi_pkg::PHYMI_RGMII);

   always_comb
   begin
      d       = q;
      pop     = 1'b0;
      d.mode  = mode_in;
      d.speed = speed_in;
      d.fd    = full_duplex_in;
      d.s1    = pins;
      d.s2    = q.s1;
      d.s3    = q.s2;
      d.txv   = 1'b0;
      d.qcnt  = tick ? quarter(q.speed) - 1'b1 : q.qcnt - 1'b1;

      // quarter-phase clock generator and receive pin drive
      if (tick)
      begin
         d.ph = q.ph + 1'b1;
         case (q.ph)
            phymi_pkg::PH_RISE:
            begin
               d.rxclk = 1'b1;
               d.txclk = 1'b1;
            end
            phymi_pkg::PH_MID_HIGH:
            begin
               if (is_rgmii)
               begin
                  d.rxd = {4'h0, q.cur.data[7:4]};
                  // falling edge carries valid xor error
                  d.dvc = q.dvc ^ (q.dvc && q.cur.err);
               end
            end
            phymi_pkg::PH_FALL:
            begin
               d.rxclk = 1'b0;
               d.txclk = 1'b0;
            end
            phymi_pkg::PH_MID_LOW:
            begin
               if (q.mode == phymi_pkg::PHYMI_MII && q.hi_pend)
               begin
                  d.rxd     = {4'h0, q.cur.data[7:4]};
                  d.hi_pend = 1'b0;
               end
               else if (fifo_valid)
               begin
                  pop       = 1'b1;
                  d.cur     = fifo_word;
                  // valid while data sits on the bus
                  d.dvc     = 1'b1;
                  d.hi_pend = (q.mode == phymi_pkg::PHYMI_MII);
                  if (q.mode == phymi_pkg::PHYMI_GMII)
                  begin
                     d.rxd = fifo_word.data;
                  end
                  else
                  begin
                     d.rxd = {4'h0, fifo_word.data[3:0]};
                  end
                  // rgmii keeps the rx error pin low
                  d.rxer = fifo_word.err && !is_rgmii;
               end
               else
               begin
                  d.cur     = '0;
                  d.dvc     = 1'b0;
                  d.rxer    = 1'b0;
                  d.rxd     = 8'h00;
                  d.hi_pend = 1'b0;
               end
            end
            default:
            begin
               d.ph = phymi_pkg::PH_RISE;
            end
         endcase
      end

      // transmit decode; the mac clock times these pins in gmii and rgmii, the device tx clock in mii
      case (q.mode)
         phymi_pkg::PHYMI_MII:
         begin
            if (tick && q.ph == phymi_pkg::PH_RISE)
            begin
               d.txact = q.s3.en;
               if (!q.s3.en)
               begin
                  d.tx_half = 1'b0;
               end
               else if (!q.tx_half)
               begin
                  d.tx_nib    = q.s3.d[3:0];
                  d.tx_nib_er = q.s3.er;
                  d.tx_half   = 1'b1;
               end
               else
               begin
                  d.txb.data    = {q.s3.d[3:0], q.tx_nib};
                  d.txb.invalid = q.s3.er || q.tx_nib_er;
                  d.txv         = 1'b1;
                  d.tx_half     = 1'b0;
               end
            end
         end
         phymi_pkg::PHYMI_GMII:
         begin
            // sampled on mac clock rising edge
            if (gtx_rise)
            begin
               d.txact = q.s3.en;
               if (q.s3.en)
               begin
                  d.txb.data    = q.s3.d;
                  d.txb.invalid = q.s3.er;
                  d.txv         = 1'b1;
               end
            end
         end
         phymi_pkg::PHYMI_RGMII:
         begin
            if (gtx_rise)
            begin
               d.tx_nib  = q.s3.d[3:0];
               d.tx_en_r = q.s3.en;
               d.txact   = q.s3.en;
            end
            else if (gtx_fall && q.tx_en_r)
            begin
               d.txb.data    = {q.s3.d[3:0], q.tx_nib};
               // falling edge control is enable xor error
               d.txb.invalid = q.tx_en_r ^ q.s3.en;
               d.txv         = 1'b1;
            end
         end
         default:
         begin
            d.txact = 1'b0;
         end
      endcase

      // collision on simultaneous activity, half duplex
      d.col = !q.fd && !is_rgmii && q.txact && line_carrier_in;
      if (is_rgmii)
      begin
         d.crs = 1'b0;
      end
      else if (!q.fd)
      begin
         d.crs = q.txact || line_carrier_in;
      end
      else
      begin
         d.crs = line_carrier_in && (q.speed != phymi_pkg::PHYMI_1000M);
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign rx_clk_out        = q.rxclk;
   assign rxd_out           = q.rxd;
   assign rx_dv_ctrl_out    = q.dvc;
   assign rx_er_out         = q.rxer;
   assign col_out           = q.col;
   assign crs_out           = q.crs;
   assign tx_clk_out        = q.txclk;
   assign tx_byte_out       = q.txb;
   assign tx_byte_valid_out = q.txv;
   assign tx_active_out     = q.txact;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   rx_upper_zero_a: assert property (
      (q.mode != phymi_pkg::PHYMI_GMII && $past(q.mode) == q.mode
       && $past(q.mode, 2) == q.mode && $past(q.ph) != phymi_pkg::PH_MID_LOW)
      |-> rxd_out[7:4] == 4'h0)
      else $error("upper rx bits driven outside gmii");

   rx_er_rgmii_a: assert property (
      $past(is_rgmii) && is_rgmii && $past(q.ph) != phymi_pkg::PH_MID_LOW
      |-> !rx_er_out)
      else $error("rx error pin driven in rgmii");

   col_full_a: assert property (
      $past(q.fd) |-> !col_out)
      else $error("collision raised in full duplex");

   rgmii_quiet_a: assert property (
      $past(is_rgmii) |-> !col_out && !crs_out)
      else $error("col or crs active in rgmii");

   col_cause_a: assert property (
      $past(!q.fd && !is_rgmii && q.txact && line_carrier_in) |-> col_out)
      else $error("collision missed in half duplex");

   crs_half_a: assert property (
      !q.fd && !is_rgmii && line_carrier_in |=> crs_out)
      else $error("carrier sense missed in half duplex");

   crs_fd_a: assert property (
      q.fd && !is_rgmii && q.speed != phymi_pkg::PHYMI_1000M
      |=> crs_out == $past(line_carrier_in))
      else $error("full duplex carrier sense wrong");

   rx_dv_pop_a: assert property (
      pop |=> rx_dv_ctrl_out ##1 rx_dv_ctrl_out || !is_rgmii)
      else $error("rx valid not raised with data");

   rx_clk_phase_a: assert property (
      tick && q.ph == phymi_pkg::PH_RISE |=> rx_clk_out && tx_clk_out)
      else $error("rx clock did not rise on phase");

   tx_err_gmii_a: assert property (
      q.mode == phymi_pkg::PHYMI_GMII && gtx_rise && q.s3.en && q.s3.er
      |=> tx_byte_valid_out && tx_byte_out.invalid)
      else $error("tx error not marked invalid");

   rx_byte_c: cover property (pop ##1 rx_dv_ctrl_out);
   tx_byte_c: cover property (tx_byte_valid_out && !tx_byte_out.invalid);
   col_c: cover property (col_out && crs_out);
   fifo_full_c: cover property (!rx_ready_out ##1 pop);

endmodule // phymi_media_if
`default_nettype wire

//--- logic/phymi_pkg.sv
// shared types and constants for the mac-side media interface
package phymi_pkg;

   // mac interface flavour and line speed
   typedef enum logic [1:0] {PHYMI_MII, PHYMI_GMII, PHYMI_RGMII} phymi_mode_t;
   typedef enum logic [1:0] {PHYMI_10M, PHYMI_100M, PHYMI_1000M} phymi_speed_t;

   // receive word from the line side: one byte plus its error flag
   typedef struct packed {
      logic       err;
      logic [7:0] data;
   } phymi_rx_word_t;

   // decoded transmit byte toward the line coder
   typedef struct packed {
      logic       invalid;
      logic [7:0] data;
   } phymi_tx_byte_t;

   // transmit pins from the mac, synchronised as one bundle
   typedef struct packed {
      logic       gtx;
      logic       en;
      logic       er;
      logic [7:0] d;
   } phymi_pins_t;

   localparam int RX_WORD_W     = 9;
   localparam int RX_FIFO_DEPTH = 32;

   // clock periods in ns
   localparam int CLK_PERIOD_NS     = 5;
   localparam int CLK10_PERIOD_NS   = 400;
   localparam int CLK100_PERIOD_NS  = 40;
   localparam int CLK1000_PERIOD_NS = 8;

   // quarter periods of the generated clocks in system cycles, at least one
   localparam int QTR10_RAW   = (CLK10_PERIOD_NS / 4) / CLK_PERIOD_NS;
   localparam int QTR100_RAW  = (CLK100_PERIOD_NS / 4) / CLK_PERIOD_NS;
   localparam int QTR1000_RAW = (CLK1000_PERIOD_NS / 4) / CLK_PERIOD_NS;
   localparam int QTR10_CYC   = (QTR10_RAW < 1) ? 1 : QTR10_RAW;
   localparam int QTR100_CYC  = (QTR100_RAW < 1) ? 1 : QTR100_RAW;
   localparam int QTR1000_CYC = (QTR1000_RAW < 1) ? 1 : QTR1000_RAW;
   localparam int QCNT_W      = 7;

   // quarter phases of the generated clocks
   localparam logic [1:0] PH_RISE     = 2'h0;
   localparam logic [1:0] PH_MID_HIGH = 2'h1;
   localparam logic [1:0] PH_FALL     = 2'h2;
   localparam logic [1:0] PH_MID_LOW  = 2'h3;

endpackage

//--- logic/phymi_fifo.sv
// receive word fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module phymi_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rd;
      logic [AW-1:0]               wr;
      logic [AW:0]                 cnt;
      logic                        rdy;
   } phymi_fifo_st_t;

   phymi_fifo_st_t q;
   phymi_fifo_st_t d;
   logic           push;
   logic           pop;

   always_comb
   begin
      d    = q;
      push = in_valid_in && q.rdy;
      pop  = out_ready_in && (q.cnt != '0);
      if (push)
      begin
         d.mem[q.wr] = in_data_in;
         d.wr        = q.wr + 1'b1;
      end
      if (pop)
      begin
         d.rd = q.rd + 1'b1;
      end
      if (push && !pop)
      begin
         d.cnt = q.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         d.cnt = q.cnt - 1'b1;
      end
      d.rdy = (d.cnt < (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign in_ready_out  = q.rdy;
   assign out_valid_out = (q.cnt != '0);
   assign out_data_out  = q.mem[q.rd];

endmodule // phymi_fifo
`default_nettype wire

//--- tb/phymi_mac_model.sv
// mac partner model: drives transmit pins, collects receive bytes
`timescale 1ns/10ps
`default_nettype none
module phymi_mac_model (
   input  wire phymi_pkg::phymi_mode_t mode_in,
   input  wire logic                   rx_clk_in,
   input  wire logic [7:0]             rxd_in,
   input  wire logic                   rx_ctl_in,
   input  wire logic                   rx_er_in,
   input  wire logic                   tx_clk_in,
   output logic                        gtx_clk_out,
   output logic [7:0]                  txd_out,
   output logic                        tx_ctl_out,
   output logic                        tx_er_out
);
   logic [8:0] rxq [$];
   logic       bad_q   = 1'b0;
   logic [3:0] lo_q    = 4'h0;
   logic       lo_ok_q = 1'b0;
   logic       lo_er_q = 1'b0;

   initial
   begin
      gtx_clk_out = 1'b0;
      txd_out     = 8'h00;
      tx_ctl_out  = 1'b0;
      tx_er_out   = 1'b0;
   end

   always #62.5 gtx_clk_out = ~gtx_clk_out;

   always @(posedge rx_clk_in)
   begin
      if (mode_in != phymi_pkg::PHYMI_GMII && rxd_in[7:4] != 4'h0)
         bad_q = 1'b1;
      if (mode_in == phymi_pkg::PHYMI_RGMII && rx_er_in)
         bad_q = 1'b1;
      if (mode_in == phymi_pkg::PHYMI_GMII && rx_ctl_in)
         rxq.push_back({rx_er_in, rxd_in});
      else if (mode_in == phymi_pkg::PHYMI_MII && !rx_ctl_in)
         lo_ok_q = 1'b0;
      else if (mode_in == phymi_pkg::PHYMI_MII && !lo_ok_q)
         {lo_ok_q, lo_er_q, lo_q} = {1'b1, rx_er_in, rxd_in[3:0]};
      else if (mode_in == phymi_pkg::PHYMI_MII)
      begin
         rxq.push_back({lo_er_q | rx_er_in, rxd_in[3:0], lo_q});
         lo_ok_q = 1'b0;
      end
      else if (mode_in == phymi_pkg::PHYMI_RGMII)
         {lo_ok_q, lo_q} = {rx_ctl_in, rxd_in[3:0]};
   end

   // high nibble and valid-xor-error on falling edge
   always @(negedge rx_clk_in)
      if (mode_in == phymi_pkg::PHYMI_RGMII && lo_ok_q)
         rxq.push_back({~rx_ctl_in, rxd_in[3:0], lo_q});

   // launch edge: device clock in mii, own clock otherwise
   task automatic edge_wait();
      if (mode_in == phymi_pkg::PHYMI_MII)
         @(negedge tx_clk_in);
      else
         @(negedge gtx_clk_out);
   endtask

   task automatic hold(input logic on);
      edge_wait();
      tx_ctl_out <= on;
      tx_er_out  <= 1'b0;
      txd_out    <= on ? 8'h05 : 8'h00;
   endtask

   // enable high with every byte, ddr in rgmii
   task automatic send(input logic [7:0] d [$], input int ei);
      foreach (d[i])
      begin
         edge_wait();
         tx_ctl_out <= 1'b1;
         tx_er_out  <= (mode_in == phymi_pkg::PHYMI_GMII) && (i == ei);
         txd_out    <= (mode_in == phymi_pkg::PHYMI_GMII) ? d[i]
                       : {4'h0, d[i][3:0]};
         if (mode_in == phymi_pkg::PHYMI_MII)
         begin
            edge_wait();
            txd_out <= {4'h0, d[i][7:4]};
         end
         else if (mode_in == phymi_pkg::PHYMI_RGMII)
         begin
            @(posedge gtx_clk_out);
            txd_out    <= {4'h0, d[i][7:4]};
            tx_ctl_out <= (i != ei);
         end
      end
      hold(1'b0);
   endtask
endmodule // phymi_mac_model
`default_nettype wire

//--- tb/phymi_media_if_tb.sv
// self-checking bench for the mac-side media interface
`timescale 1ns/10ps
`default_nettype none
module phymi_media_if_tb;
   logic                      clk_in    = 1'b0;
   logic                      rst_in    = 1'b1;
   phymi_pkg::phymi_mode_t    mode      = phymi_pkg::PHYMI_GMII;
   phymi_pkg::phymi_speed_t   speed     = phymi_pkg::PHYMI_1000M;
   logic                      fd        = 1'b1;
   logic                      carrier   = 1'b0;
   phymi_pkg::phymi_rx_word_t rx_word   = '0;
   logic                      rx_valid  = 1'b0;
   logic                      rx_ready;
   logic                      gtx;
   logic [7:0]                txd;
   logic                      tx_ctl;
   logic                      tx_er;
   logic                      rx_clk;
   logic [7:0]                rxd;
   logic                      rx_ctl;
   logic                      rx_er;
   logic                      col;
   logic                      crs;
   logic                      tx_clk;
   phymi_pkg::phymi_tx_byte_t tx_byte;
   logic                      tx_valid;
   logic                      tx_active;
   logic [8:0]                txq [$];
   int                        n_mismatch = 0;
   int                        num_checks = 0;
   int                        n_refused  = 0;
   int                        cyc        = 0;

   always #2.5 clk_in = ~clk_in;

   phymi_media_if DUT (
      .clk_in(clk_in), .rst_in(rst_in), .mode_in(mode),
      .speed_in(speed), .full_duplex_in(fd), .line_carrier_in(carrier),
      .rx_word_in(rx_word), .rx_valid_in(rx_valid),
      .rx_ready_out(rx_ready), .gtx_clk_in(gtx), .txd_in(txd),
      .tx_en_ctrl_in(tx_ctl), .tx_er_in(tx_er), .rx_clk_out(rx_clk),
      .rxd_out(rxd), .rx_dv_ctrl_out(rx_ctl), .rx_er_out(rx_er),
      .col_out(col), .crs_out(crs), .tx_clk_out(tx_clk),
      .tx_byte_out(tx_byte), .tx_byte_valid_out(tx_valid),
      .tx_active_out(tx_active)
   );

   phymi_mac_model mac (
      .mode_in(mode), .rx_clk_in(rx_clk), .rxd_in(rxd),
      .rx_ctl_in(rx_ctl), .rx_er_in(rx_er), .tx_clk_in(tx_clk),
      .gtx_clk_out(gtx), .txd_out(txd), .tx_ctl_out(tx_ctl),
      .tx_er_out(tx_er)
   );

   task automatic give_verdict();
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // collect decoded transmit bytes, cut a hang short
   always @(posedge clk_in)
   begin
      cyc++;
      if (tx_valid === 1'b1)
         txq.push_back(tx_byte);
      if (cyc == 50000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic cmp_word(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      cmp_word({8'h00, got}, {8'h00, exp});
   endtask

   task automatic setup(input phymi_pkg::phymi_mode_t m,
                        input phymi_pkg::phymi_speed_t s,
                        input logic f, input logic c);
      @(posedge clk_in);
      mode    <= m;
      speed   <= s;
      fd      <= f;
      carrier <= c;
      repeat (4) @(posedge clk_in);
   endtask

   // hold the word until the edge that finds ready high
   task automatic push(input logic [8:0] w);
      int t;
      rx_word  <= w;
      rx_valid <= 1'b1;
      t = 0;
      do
      begin
         @(posedge clk_in);
         t++;
         if (rx_ready !== 1'b1)
            n_refused++;
      end while (rx_ready !== 1'b1 && t < 2000);
   endtask

   task automatic scen_rx(input phymi_pkg::phymi_mode_t m,
                          input phymi_pkg::phymi_speed_t s, input int n);
      int i;
      int t;
      setup(m, s, 1'b1, 1'b0);
      mac.rxq.delete();
      mac.bad_q = 1'b0;
      n_refused = 0;
      for (i = 0; i < n; i++)
         push({i == 2, 8'hA5 + 8'(i * 7)});
      rx_valid <= 1'b0;
      t = 0;
      while (mac.rxq.size() < n && t < 20000)
      begin
         @(posedge clk_in);
         t++;
      end
      cmp_word(9'(mac.rxq.size()), 9'(n));
      for (i = 0; i < n; i++)
         cmp_word(mac.rxq[i], {i == 2, 8'hA5 + 8'(i * 7)});
      cmp_flag(mac.bad_q, 1'b0);
      cmp_flag(n_refused != 0, n > phymi_pkg::RX_FIFO_DEPTH);
   endtask

   task automatic scen_tx(input phymi_pkg::phymi_mode_t m,
                          input phymi_pkg::phymi_speed_t s,
                          input int n, input int ei);
      logic [7:0] d [$];
      int         i;
      int         t;
      setup(m, s, 1'b1, 1'b0);
      txq.delete();
      for (i = 0; i < n; i++)
         d.push_back(8'h3C + 8'(i * 5));
      mac.send(d, ei);
      t = 0;
      while (txq.size() < n && t < 2000)
      begin
         @(posedge clk_in);
         t++;
      end
      cmp_word(9'(txq.size()), 9'(n));
      foreach (d[k])
         cmp_word(txq[k], {k == ei, d[k]});
   endtask

   task automatic scen_cs(input phymi_pkg::phymi_mode_t m,
                          input phymi_pkg::phymi_speed_t s, input logic f,
                          input logic c, input logic ecol, input logic ecrs);
      int t;
      setup(m, s, f, c);
      mac.hold(1'b1);
      t = 0;
      while (tx_active !== 1'b1 && t < 400)
      begin
         @(posedge clk_in);
         t++;
      end
      repeat (3) @(posedge clk_in);
      cmp_flag(tx_active, 1'b1);
      cmp_flag(col, ecol);
      cmp_flag(crs, ecrs);
      mac.hold(1'b0);
      repeat (60) @(posedge clk_in);
   endtask

   // rx and tx clock periods, from the spacing of later rising edges
   task automatic scen_clk(input phymi_pkg::phymi_speed_t s, input int p);
      logic [1:0] last;
      int         t;
      int         e;
      int         r [$];
      int         x [$];
      setup(phymi_pkg::PHYMI_MII, s, 1'b1, 1'b0);
      e    = p / phymi_pkg::CLK_PERIOD_NS;
      last = 2'h3;
      t    = 0;
      while ((r.size() < 3 || x.size() < 3) && t < 600)
      begin
         @(posedge clk_in);
         t++;
         if (rx_clk === 1'b1 && last[0] === 1'b0)
            r.push_back(t);
         if (tx_clk === 1'b1 && last[1] === 1'b0)
            x.push_back(t);
         last = {tx_clk, rx_clk};
      end
      cmp_word(9'(r[2] - r[1]), 9'(e));
      cmp_word(9'(x[2] - x[1]), 9'(e));
   endtask

   initial
   begin
      repeat (10) @(posedge clk_in);
      cmp_flag(rx_ready, 1'b0);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      scen_rx(phymi_pkg::PHYMI_GMII, phymi_pkg::PHYMI_1000M, 6);
      scen_rx(phymi_pkg::PHYMI_RGMII, phymi_pkg::PHYMI_1000M, 6);
      scen_rx(phymi_pkg::PHYMI_MII, phymi_pkg::PHYMI_100M, 4);
      scen_rx(phymi_pkg::PHYMI_MII, phymi_pkg::PHYMI_10M, 40);
      scen_tx(phymi_pkg::PHYMI_GMII, phymi_pkg::PHYMI_1000M, 5, 3);
      scen_tx(phymi_pkg::PHYMI_RGMII, phymi_pkg::PHYMI_1000M, 5, 1);
      scen_tx(phymi_pkg::PHYMI_MII, phymi_pkg::PHYMI_10M, 3, -1);
      scen_cs(phymi_pkg::PHYMI_GMII, phymi_pkg::PHYMI_1000M,
              1'b0, 1'b1, 1'b1, 1'b1);
      scen_cs(phymi_pkg::PHYMI_GMII, phymi_pkg::PHYMI_1000M,
              1'b0, 1'b0, 1'b0, 1'b1);
      scen_cs(phymi_pkg::PHYMI_GMII, phymi_pkg::PHYMI_1000M,
              1'b1, 1'b1, 1'b0, 1'b0);
      scen_cs(phymi_pkg::PHYMI_MII, phymi_pkg::PHYMI_100M,
              1'b1, 1'b1, 1'b0, 1'b1);
      scen_cs(phymi_pkg::PHYMI_MII, phymi_pkg::PHYMI_100M,
              1'b1, 1'b0, 1'b0, 1'b0);
      scen_cs(phymi_pkg::PHYMI_RGMII, phymi_pkg::PHYMI_1000M,
              1'b0, 1'b1, 1'b0, 1'b0);
      scen_clk(phymi_pkg::PHYMI_10M, phymi_pkg::CLK10_PERIOD_NS);
      scen_clk(phymi_pkg::PHYMI_100M, phymi_pkg::CLK100_PERIOD_NS);
      give_verdict();
   end
endmodule // phymi_media_if_tb
`default_nettype wire
